// file: src/loader_cfg.svh
// Purpose: Offsets, field positions, reset values and timing for the loader
// Assumes: Word-aligned Wishbone slave with 32-bit data
// Notes: Definitions only
`ifndef LOADER_CFG_SVH
`define LOADER_CFG_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_WRCNT 8'h08
`define REG_FRCNT 8'h0C
`define REG_CAP 8'h10
// Control register fields
`define CTRL_LEN_LSB 0
`define CTRL_LEN_MSB 15
`define CTRL_CMT_LSB 16
`define CTRL_CMT_MSB 20
`define CTRL_FR_LSB 24
`define CTRL_FR_MSB 26
`define CTRL_RESET 32'h0000_0FA0
// Status bit for a refused cassette write, cleared by writing one
`define STAT_REFUSED 8
// Storage block limits and sizes
`define CMT_BLOCKS_MAX 5'h18
`define FR_BLOCKS_MAX 3'h4
`define STEPS_PER_BLOCK 16'h01F4
`define CMT_PTS_PER_BLOCK 16'h0032
`define FR_PTS_PER_BLOCK 16'h01F4
// Lamp blink half period
`define BLINK_HALF_MS 250
`define CLK_MHZ 100
`define BLINK_HALF_CYC ((`BLINK_HALF_MS) * (`CLK_MHZ) * 1000)
`endif

// file: src/loader_pkg.sv
// Purpose: Types shared by the loader
// Assumes: Nothing
// Notes: Constants live in loader_cfg.svh
package loader_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ARM_LOAD, ST_ARM_BACK, ST_COPY} ldr_state_t;
    // Copy direction: into internal EEPROM or into the cassette
    typedef enum logic {DIR_LOAD, DIR_BACKUP} copy_dir_t;
endpackage : loader_pkg

// file: src/cassette_loader_keys.sv
// Purpose: Key-driven copy between memory cassette and internal EEPROM
// Assumes: Inputs synchronous to clk_i; memories answer with one-cycle acks
// Notes: Copy data passes through a small FIFO
// Operation
// - Transfers only accepted while controller is stopped; presses while running ignored.
// - Load key press when idle lights load lamp steadily and arms load.
// - Backup key press while load armed cancels back to idle.
// - Second load press starts cassette-to-EEPROM copy; load lamp blinks meanwhile.
// - Load lamp goes off when the load copy finishes.
// - Backup key press when idle lights backup lamp steadily and arms backup.
// - Load key press while backup armed cancels back to idle.
// - Second backup press starts EEPROM-to-cassette copy; backup lamp blinks meanwhile.
// - Backup lamp goes off when the backup copy finishes.
// - No cassette write while the lock switch is on.
// - Continuous block copy to file register flash-writes every cycle; edge form once.
// - Comment storage is 0 to 24 blocks of 50 points, 500 steps each.
// - File register storage is 0 to 4 blocks of 500 points, 500 steps each.
// - With a cassette fitted, the cassette program is executed.
`timescale 1ns/100ps
`include "loader_cfg.svh"
// ****************************************************************
// Copy FIFO
// ****************************************************************
module copy_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    // Honest full and empty from the fill count
    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rp_q];
    // Storage write
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wp_q] <= in_data_i;
    end
    // Pointers and count
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_i)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : copy_fifo
// ****************************************************************
// Loader top
// ****************************************************************
module cassette_loader_keys
    import loader_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 16,
    parameter int FIFO_DEPTH = 8,
    parameter int BLINK_HALF = `BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Operator side
    input wire logic key_load_i,
    input wire logic key_backup_i,
    input wire logic lock_on_i,
    input wire logic run_i,
    input wire logic cassette_present_i,
    output logic lamp_load_o,
    output logic lamp_backup_o,
    output logic exec_from_cassette_o,
    // Block copy instruction into a file register
    input wire logic blk_copy_active_i,
    input wire logic blk_copy_edge_form_i,
    output logic fr_flash_wr_o,
    // Memory read port, sel 1 = cassette, 0 = internal EEPROM
    output logic rd_req_o,
    output logic rd_sel_o,
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic rd_ack_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    // Memory write port, same selection
    output logic wr_req_o,
    output logic wr_sel_o,
    output logic [ADDR_W-1:0] wr_addr_o,
    output logic [DATA_W-1:0] wr_data_o,
    input wire logic wr_ack_i
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    ldr_state_t state_q, state_d;
    copy_dir_t dir_q;
    logic key_load_q, key_backup_q, blk_prev_q;
    logic [31:0] ctrl_q;
    logic refused_q;
    logic [15:0] wrcnt_q, frcnt_q;
    logic [31:0] blink_cnt_q;
    logic blink_q;
    logic [ADDR_W-1:0] rd_ptr_q, wr_ptr_q;
    logic rd_busy_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic fifo_in_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    // ****************************************************************
    // Key edges and state decode
    // ****************************************************************
    // Single presses are rising edges of the key levels
    wire load_press = key_load_i & ~key_load_q;
    wire backup_press = key_backup_i & ~key_backup_q;
    wire keys_live = ~run_i;
    wire [ADDR_W-1:0] copy_len = ADDR_W'(ctrl_q[`CTRL_LEN_MSB:`CTRL_LEN_LSB]);
    wire to_cassette = (dir_q == DIR_BACKUP);
    wire copying = (state_q == ST_COPY);
    wire copy_done = copying && (wr_ptr_q == copy_len);
    wire backup_start = (state_q == ST_ARM_BACK) && keys_live && backup_press;
    wire refuse_now = backup_start && lock_on_i;
    wire wb_req = cyc_i & stb_i & ~ack_q;
    wire wb_wr = wb_req & we_i;
    wire dir_next_backup = (state_q == ST_ARM_BACK);
    // Next state of the key sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (keys_live && load_press)
                    state_d = ST_ARM_LOAD;
                else if (keys_live && backup_press)
                    state_d = ST_ARM_BACK;
            ST_ARM_LOAD:
                if (!keys_live)
                    state_d = ST_IDLE;
                else if (backup_press)
                    state_d = ST_IDLE;
                else if (load_press)
                    state_d = ST_COPY;
            ST_ARM_BACK:
                if (!keys_live)
                    state_d = ST_IDLE;
                else if (load_press)
                    state_d = ST_IDLE;
                else if (backup_press)
                    state_d = lock_on_i ? ST_IDLE : ST_COPY;
            ST_COPY:
                if (copy_done)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end
    // Sequencer registers and key history
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_IDLE;
            dir_q <= DIR_LOAD;
            key_load_q <= 1'b0;
            key_backup_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            key_load_q <= key_load_i;
            key_backup_q <= key_backup_i;
            if (state_d == ST_COPY && !copying)
                dir_q <= dir_next_backup ? DIR_BACKUP : DIR_LOAD;
        end
    end
    // ****************************************************************
    // Lamps
    // ****************************************************************
    // Blink divider runs only while copying
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !copying)
        begin
            blink_cnt_q <= '0;
            blink_q <= 1'b1;
        end
        else if (blink_cnt_q == 32'(BLINK_HALF - 1))
        begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
    // Steady when armed, blinking while copying, off otherwise
    assign lamp_load_o = (state_q == ST_ARM_LOAD)
        | (copying & ~to_cassette & blink_q);
    assign lamp_backup_o = (state_q == ST_ARM_BACK)
        | (copying & to_cassette & blink_q);
    assign exec_from_cassette_o = cassette_present_i;
    // ****************************************************************
    // Copy engine
    // ****************************************************************
    // Reads stall on a full FIFO; one read outstanding at a time
    assign rd_req_o = copying & rd_busy_q;
    assign rd_sel_o = ~to_cassette;
    assign rd_addr_o = rd_ptr_q;
    assign wr_req_o = copying & fifo_out_valid & ~(to_cassette & lock_on_i);
    assign wr_sel_o = to_cassette;
    assign wr_addr_o = wr_ptr_q;
    assign wr_data_o = fifo_out_data;
    wire rd_take = rd_req_o & rd_ack_i;
    wire wr_take = wr_req_o & wr_ack_i;
    // Read and write pointers
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !copying)
        begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            rd_busy_q <= 1'b0;
        end
        else
        begin
            if (rd_take)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
                rd_busy_q <= 1'b0;
            end
            else if (!rd_busy_q && fifo_in_ready && rd_ptr_q != copy_len)
                rd_busy_q <= 1'b1;
            if (wr_take)
                wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end
    // Data buffer between read and write ports
    copy_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(~copying),
        .in_valid_i(rd_take),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rd_data_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(wr_ack_i & wr_req_o),
        .out_data_o(fifo_out_data)
    );
    // ****************************************************************
    // File register flash writes and endurance counting
    // ****************************************************************
    // Continuous form writes every cycle, edge form on rising condition
    assign fr_flash_wr_o = blk_copy_active_i & (~blk_copy_edge_form_i | ~blk_prev_q);
    wire load_finished = copy_done & ~to_cassette;
    // Saturating counts for software to watch: finished load copies plus flash writes, and flash writes alone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            blk_prev_q <= 1'b0;
            wrcnt_q <= '0;
            frcnt_q <= '0;
        end
        else
        begin
            blk_prev_q <= blk_copy_active_i;
            if ((load_finished || fr_flash_wr_o) && wrcnt_q != 16'hFFFF)
                wrcnt_q <= wrcnt_q + 16'h0001;
            if (fr_flash_wr_o && frcnt_q != 16'hFFFF)
                frcnt_q <= frcnt_q + 16'h0001;
        end
    end
    // ****************************************************************
    // Capacity decode
    // ****************************************************************
    wire [4:0] cmt_blk = ctrl_q[`CTRL_CMT_MSB:`CTRL_CMT_LSB];
    wire [2:0] fr_blk = ctrl_q[`CTRL_FR_MSB:`CTRL_FR_LSB];
    wire [15:0] cap_steps = 16'((16'(cmt_blk) + 16'(fr_blk)) * `STEPS_PER_BLOCK);
    wire [15:0] cmt_pts = 16'(16'(cmt_blk) * `CMT_PTS_PER_BLOCK);
    wire [15:0] fr_pts = 16'(16'(fr_blk) * `FR_PTS_PER_BLOCK);
    wire [4:0] cmt_wr = dat_i[`CTRL_CMT_MSB:`CTRL_CMT_LSB];
    wire [2:0] fr_wr = dat_i[`CTRL_FR_MSB:`CTRL_FR_LSB];
    // Block counts above the limits clamp to the limits
    wire [4:0] cmt_clamp = (cmt_wr > `CMT_BLOCKS_MAX) ? `CMT_BLOCKS_MAX : cmt_wr;
    wire [2:0] fr_clamp = (fr_wr > `FR_BLOCKS_MAX) ? `FR_BLOCKS_MAX : fr_wr;
    // Control write word and byte lane mask; unused bits stay zero
    wire [31:0] ctrl_wr = {5'h00, fr_clamp, 3'h0, cmt_clamp, dat_i[`CTRL_LEN_MSB:`CTRL_LEN_LSB]};
    wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    wire [31:0] stat_word = {20'h00000, 3'h0, refused_q, 1'b0, lock_on_i,
        cassette_present_i, run_i, 1'b0, dir_q, state_q};
    wire [31:0] rd_mux =
        (adr_i == `REG_CTRL) ? ctrl_q :
        (adr_i == `REG_STAT) ? stat_word :
        (adr_i == `REG_WRCNT) ? {16'h0000, wrcnt_q} :
        (adr_i == `REG_FRCNT) ? {16'h0000, frcnt_q} :
        (adr_i == `REG_CAP) ? {cmt_pts, cap_steps} : 32'h0000_0000;
    wire ctrl_we = wb_wr && adr_i == `REG_CTRL && copying == 1'b0;
    wire stat_we = wb_wr && adr_i == `REG_STAT && sel_i[1];
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    // Control register, refused flag, ack and read data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `CTRL_RESET;
            refused_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= wb_req;
            dat_q <= wb_req ? rd_mux : 32'h0000_0000;
            if (ctrl_we)
                ctrl_q <= (ctrl_q & ~lane_mask) | (ctrl_wr & lane_mask);
            // Set wins over a clear in the same cycle
            if (refuse_now)
                refused_q <= 1'b1;
            else if (stat_we && dat_i[`STAT_REFUSED])
                refused_q <= 1'b0;
        end
    end
endmodule : cassette_loader_keys

// file: bench/cassette_mem.sv
// Purpose: Cassette and internal EEPROM behind the loader memory ports
// Assumes: One request per port at a time, held until acknowledged
// Notes: Wait states vary with address; idle read data keeps toggling
`timescale 1ns/100ps
// ********************
// Memory pair model
// ********************
module cassette_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lock_on_i,
    input wire logic rd_req_i,
    input wire logic rd_sel_i,
    input wire logic [15:0] rd_addr_i,
    output logic rd_ack_o,
    output logic [15:0] rd_data_o,
    input wire logic wr_req_i,
    input wire logic wr_sel_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    output logic wr_ack_o
);
    logic [15:0] cas_q [64];
    logic [15:0] ee_q [64];
    logic [1:0] rdly_q;
    logic [1:0] wdly_q;
    int ee_n;
    int cas_n;
    int bad_n;
    // Read port, 0 to 3 wait cycles
    always_ff @(posedge clk_i)
    begin
        rd_ack_o <= 1'b0;
        if (rst_i)
        begin
            rdly_q <= 2'h0;
            rd_data_o <= 16'h0000;
        end
        else if (rd_req_i && !rd_ack_o && rdly_q == 2'h0)
        begin
            rd_ack_o <= 1'b1;
            rd_data_o <= rd_sel_i ? cas_q[rd_addr_i[5:0]] : ee_q[rd_addr_i[5:0]];
            rdly_q <= rd_addr_i[1:0];
        end
        else
        begin
            rd_data_o <= ~rd_data_o; // Stale data never looks valid
            if (rd_req_i && !rd_ack_o)
                rdly_q <= rdly_q - 2'h1;
        end
    end
    // Write port and contents
    always_ff @(posedge clk_i)
    begin
        wr_ack_o <= 1'b0;
        if (rst_i)
        begin
            wdly_q <= 2'h0;
            ee_n <= 0;
            cas_n <= 0;
            bad_n <= 0;
            for (int i = 0; i < 64; i++)
            begin
                cas_q[i] <= 16'hC000 + 16'(i);
                ee_q[i] <= 16'hE000 + 16'(i);
            end
        end
        else if (wr_req_i && !wr_ack_o && wdly_q == 2'h0)
        begin
            wr_ack_o <= 1'b1;
            wdly_q <= ~wr_addr_i[1:0];
            if (wr_sel_i)
            begin
                cas_q[wr_addr_i[5:0]] <= wr_data_i;
                cas_n <= cas_n + 1;
                bad_n <= bad_n + int'(lock_on_i); // Write while locked
            end
            else
            begin
                ee_q[wr_addr_i[5:0]] <= wr_data_i;
                ee_n <= ee_n + 1; // Endurance use, kept tiny
            end
        end
        else if (wr_req_i && !wr_ack_o)
            wdly_q <= wdly_q - 2'h1;
    end
endmodule : cassette_mem

// file: bench/cassette_loader_keys_properties.sv
// Purpose: Port properties of the cassette loader
// Assumes: Bound into cassette_loader_keys
// Notes: Idle means both lamps dark longer than one blink phase
`timescale 1ns/100ps
// ********************
// Checker
// ********************
module loader_checker #(
    parameter int ADDR_W = 16,
    parameter int BLINK_HALF = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic key_load_i,
    input wire logic key_backup_i,
    input wire logic lock_on_i,
    input wire logic run_i,
    input wire logic cassette_present_i,
    input wire logic lamp_load_o,
    input wire logic lamp_backup_o,
    input wire logic exec_from_cassette_o,
    input wire logic blk_copy_active_i,
    input wire logic blk_copy_edge_form_i,
    input wire logic fr_flash_wr_o,
    input wire logic rd_req_o,
    input wire logic rd_sel_o,
    input wire logic [ADDR_W-1:0] rd_addr_o,
    input wire logic rd_ack_i,
    input wire logic wr_req_o,
    input wire logic wr_sel_o
);
    logic [7:0] dark_q;
    logic idle_w;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles with both lamps dark
    assign idle_w = dark_q > BLINK_HALF + 1;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || lamp_load_o || lamp_backup_o)
            dark_q <= 8'h00;
        else if (dark_q != 8'hFF)
            dark_q <= dark_q + 8'h01;
    end
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not acknowledged");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    a_run_ignore: assert property (
        run_i && idle_w && ($rose(key_load_i) || $rose(key_backup_i))
        |=> (!lamp_load_o && !lamp_backup_o) [*4])
        else $error("key taken while running");
    a_load_arm: assert property (
        !run_i && idle_w && $rose(key_load_i) && !key_backup_i
        |-> ##[1:3] lamp_load_o && !lamp_backup_o)
        else $error("load key did not arm");
    a_back_arm: assert property (
        !run_i && idle_w && $rose(key_backup_i) && !key_load_i
        |-> ##[1:3] lamp_backup_o && !lamp_load_o)
        else $error("backup key did not arm");
    a_lock_guard: assert property (
        lock_on_i && $past(lock_on_i) |-> !(wr_req_o && wr_sel_o))
        else $error("cassette write while locked");
    a_flash_cont: assert property (
        blk_copy_active_i && !blk_copy_edge_form_i |-> fr_flash_wr_o)
        else $error("continuous block copy missed a flash write");
    a_flash_once: assert property (
        blk_copy_edge_form_i && blk_copy_active_i && $past(blk_copy_active_i)
        |-> !fr_flash_wr_o)
        else $error("edge block copy wrote flash again");
    a_exec_source: assert property (exec_from_cassette_o == cassette_present_i)
        else $error("program source differs from cassette presence");
    a_rd_hold: assert property (rd_req_o && !rd_ack_i
        |=> rd_req_o && $stable(rd_addr_o) && $stable(rd_sel_o))
        else $error("read request dropped before answer");
    cover property (lamp_load_o && rd_req_o);
    cover property (wr_req_o && wr_sel_o);
    cover property (fr_flash_wr_o && blk_copy_edge_form_i);
endmodule : loader_checker
bind cassette_loader_keys loader_checker #(.ADDR_W(ADDR_W), .BLINK_HALF(BLINK_HALF)) u_chk (.*);

// file: bench/cassette_loader_keys_test.sv
// Purpose: Self-checking bench for the cassette loader
// Assumes: Design answers the bus one cycle after the request
// Notes: Blink half period shortened to BH cycles
`timescale 1ns/100ps
// ********************
// Bench top
// ********************
module cassette_loader_keys_test;
    localparam int BH = 4;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic key_load_i = 1'b0, key_backup_i = 1'b0, lock_on_i = 1'b0, run_i = 1'b0;
    logic cassette_present_i = 1'b0, blk_copy_active_i = 1'b0, blk_copy_edge_form_i = 1'b0;
    logic ack_o, lamp_load_o, lamp_backup_o, exec_from_cassette_o, fr_flash_wr_o;
    logic rd_req_o, rd_sel_o, rd_ack_i, wr_req_o, wr_sel_o, wr_ack_i;
    logic [15:0] rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
    logic [31:0] exp_q[$], msk_q[$];
    int n_fail = 0, checked = 0, seed = 32'h94A7, len, rises, cnt;
    always #5 clk_i = ~clk_i;
    cassette_loader_keys #(.BLINK_HALF(BH)) u_cassette_loader_keys (.*);
    cassette_mem u_cassette_mem (.clk_i(clk_i), .rst_i(rst_i), .lock_on_i(lock_on_i),
        .rd_req_i(rd_req_o), .rd_sel_i(rd_sel_o), .rd_addr_i(rd_addr_o), .rd_ack_o(rd_ack_i),
        .rd_data_o(rd_data_i), .wr_req_i(wr_req_o), .wr_sel_i(wr_sel_o),
        .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .wr_ack_o(wr_ack_i));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task end_sim;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // Single bus cycle, read expectations queued
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        if (!w)
        begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        // Only the watchdog ends a wait for the acknowledge
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'b00;
    endtask : wb
    // Read data compared with the oldest note
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0)
            check("read data", dat_o & msk_q.pop_front(), exp_q.pop_front());
    end
    task press(input logic ld);
        @(posedge clk_i);
        {key_load_i, key_backup_i} <= {ld, !ld};
        repeat (2) @(posedge clk_i);
        {key_load_i, key_backup_i} <= 2'b00;
        repeat (BH + 3) @(posedge clk_i);
    endtask : press
    task lamps(input logic [1:0] e);
        check("lamps", {30'h0, lamp_load_o, lamp_backup_o}, {30'h0, e});
    endtask : lamps
    // Wait for the lamp to stay dark, counting blink rises
    task wait_done(input logic ld);
        int off;
        logic l, p;
        {off, rises, p} = {32'h0, 32'h0, 1'b1};
        while (off <= BH + 1)
        begin
            @(posedge clk_i);
            l = ld ? lamp_load_o : lamp_backup_o;
            rises += (l === 1'b1 && p === 1'b0);
            off = (l === 1'b0) ? off + 1 : 0;
            p = l;
        end
    endtask : wait_done
    task flash(input logic ef);
        cnt = 0;
        @(posedge clk_i);
        {blk_copy_edge_form_i, blk_copy_active_i} <= {ef, 1'b1};
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_i);
            cnt += (fr_flash_wr_o === 1'b1);
            if (i == 2)
                blk_copy_active_i <= 1'b0;
        end
    endtask : flash
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        $display("unexpected watchdog: expected finish seen hang");
        end_sim;
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        len = 16 + ($random(seed) & 15); // Copy outlasts the presses made during it
        wb(0, 8'h00, 32'h0000_0FA0, 32'hFFFF_FFFF);
        wb(1, 8'h14, 32'hFFFF_FFFF, 32'h0);
        wb(0, 8'h14, 32'h0, 32'hFFFF_FFFF);
        wb(0, 8'h10, 32'h0, 32'hFFFF_FFFF);
        wb(1, 8'h00, {5'h00, 3'h7, 3'h0, 5'h1F, 16'(len)}, 32'h0);
        wb(0, 8'h10, 32'h04B0_36B0, 32'hFFFF_FFFF);
        $display("done registers");
        press(1); lamps(2'b10);
        press(0); lamps(2'b00);
        press(0); lamps(2'b01);
        press(1); lamps(2'b00);
        run_i <= 1'b1;
        press(1); lamps(2'b00);
        press(0); lamps(2'b00);
        run_i <= 1'b0;
        $display("done keys");
        lock_on_i <= 1'b1;
        press(1); press(1); press(0);
        check("backup lamp", lamp_backup_o, 32'h0);
        wait_done(1);
        check("blink", rises > 0, 32'h1);
        lamps(2'b00);
        check("eeprom writes", u_cassette_mem.ee_n, len);
        check("cassette writes", u_cassette_mem.cas_n, 32'h0);
        for (int i = 0; i < len; i++)
            check("eeprom word", u_cassette_mem.ee_q[i], 16'hC000 + i);
        $display("done load copy");
        press(0); press(0); lamps(2'b00);
        wb(0, 8'h04, 32'h100, 32'h100);
        wb(1, 8'h04, 32'h100, 32'h0);
        wb(0, 8'h04, 32'h0, 32'h100);
        lock_on_i <= 1'b0;
        len = len + 2;
        wb(1, 8'h00, len, 32'h0);
        press(0); press(0); wait_done(0);
        check("blink", rises > 0, 32'h1);
        lamps(2'b00);
        check("locked writes", u_cassette_mem.bad_n, 32'h0);
        check("cassette writes", u_cassette_mem.cas_n, len);
        for (int i = 0; i < len; i++)
            check("cassette word", u_cassette_mem.cas_q[i],
                (i < len - 2 ? 16'hC000 : 16'hE000) + i);
        $display("done backup copy");
        flash(0); check("flash count", cnt, 32'h3);
        flash(1); check("flash count", cnt, 32'h1);
        wb(0, 8'h0C, 32'h4, 32'hFFFF_FFFF);
        wb(0, 8'h08, 32'h5, 32'hFFFF_FFFF);
        repeat (8)
        begin
            @(posedge clk_i);
            check("program source", exec_from_cassette_o, cassette_present_i);
            cassette_present_i <= $random(seed);
        end
        $display("done flash and source");
        end_sim;
    end
endmodule : cassette_loader_keys_test
